// ---- adb_defines.svh ----
// Shared constants of the busy-indicator serial converter link
`ifndef ADB_DEFINES_SVH
`define ADB_DEFINES_SVH

`define ADB_RES_W       16
`define ADB_CFG_W       14
`define ADB_SH_W        30
`define ADB_CFG_RST     14'h0001
`define ADB_CFG_RBDIS   0
`define ADB_PIN_CNV     2
`define ADB_PIN_SCK     1
`define ADB_PIN_DIN     0
`define ADB_PIN_IDLE    3'h2
`define ADB_CFG_BITS    4'hE
`define ADB_RES_BITS    5'h10
`define ADB_ALL_BITS    5'h1E
`define ADB_CLK_MHZ     200
`define ADB_CONVERSION_TIME_NS    1600
`define ADB_TDATA_NS    1200
`define ADB_CNV_HI_NS   40
`define ADB_SCK_HALF_NS 80
`define ADB_CYC_UP(ns)  ((((ns) * `ADB_CLK_MHZ) + 999) / 1000)
`define ADB_CYC_DN(ns)  (((ns) * `ADB_CLK_MHZ) / 1000)
`define ADB_CONVERSION_TIME_CYC   `ADB_CYC_UP(`ADB_CONVERSION_TIME_NS)
`define ADB_TDATA_CYC   `ADB_CYC_DN(`ADB_TDATA_NS)
`define ADB_CNV_HI_CYC  `ADB_CYC_UP(`ADB_CNV_HI_NS)
`define ADB_SCK_HALF_CYC `ADB_CYC_UP(`ADB_SCK_HALF_NS)
`define ADB_AXI_AW      8
`define ADB_REG_CTRL    8'h00
`define ADB_REG_CFG     8'h04
`define ADB_REG_STAT    8'h08
`define ADB_REG_RES     8'h0C
`define ADB_REG_RBCFG   8'h10
`define ADB_CTRL_START  0
`define ADB_STAT_BUSY   0
`define ADB_STAT_DONE   1
`define ADB_RESP_OK     2'h0
`define ADB_RESP_ERR    2'h2

`endif

// ---- adb_pkg.sv ----
// Types shared by both ends of the converter link
package adb_pkg;
  typedef logic [15:0] adb_res_t;
  typedef logic [13:0] adb_cfg_t;
  typedef enum logic {ADB_DEV_ACQ, ADB_DEV_CONV} adb_dev_e;
  typedef enum logic [2:0] {HS_IDLE, HS_CNV, HS_WAIT, HS_LOW, HS_HIGH} adb_host_e;
endpackage : adb_pkg

// ---- adb_link_if.sv ----
// Serial link between the converter and its host controller
`timescale 1ns/100ps
interface adb_link_if;
  logic conversion_start;
  logic sck;
  logic din;
  logic sdo_o;
  logic sdo_oe;
  logic sdo;

  // Pull-up resolves the floated data line high
  assign sdo = sdo_oe ? sdo_o : 1'b1;

  modport dev  (input conversion_start, input sck, input din, output sdo_o, output sdo_oe);
  modport host (output conversion_start, output sck, output din, input sdo);
endinterface : adb_link_if

// ---- adb_dev.sv ----
// Converter end: conversion timing, busy indicator, serial shift logic
`timescale 1ns/100ps
`include "adb_defines.svh"

// What this block does
// - Host idles clock high, phase one
// - Start edge converts, floats output, ignores input
// - Started conversion always runs to completion
// - Host keeps start low through conversion
// - Conversion end drives output low as busy
// - After conversion, acquire and stay idle
// - Host presents config MSB at conversion end
// - First 14 rising edges shift config in
// - First 16 falling edges shift result out
// - Host finishes transfer inside safe window
// - Only a complete 14-bit write applies
// - Unread result lost when window ends
// - Output bit holds across following two edges
// - Host may capture on either edge
// - No readback: 17th falling edge floats output
// - Without 17th edge last bit stays driven
// - Readback: config word follows result, MSB first
// - Readback: 31st falling edge floats output
// - Config LSB one disables readback
module adb_dev #(
  parameter int CONV_CYC  = `ADB_CONVERSION_TIME_CYC,
  parameter int TDATA_CYC = `ADB_TDATA_CYC
) (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              CE,
  adb_link_if.dev                LINK,
  input  wire adb_pkg::adb_res_t SAMPLE,
  output      adb_pkg::adb_cfg_t CFG_OUT,
  output      logic              CONV_BUSY,
  output      logic              CONV_DONE,
  output      logic              CFG_APPLIED,
  output      logic              RESULT_LOST
);
  import adb_pkg::*;

  logic [2:0]          pin_a_r;
  logic [2:0]          pin_b_r;
  logic [2:0]          pin_c_r;
  logic                cnv_s;
  logic                din_s;
  logic                cnv_rise;
  logic                sck_rise;
  logic                sck_fall;
  adb_dev_e            state_r;
  logic [15:0]         conv_cnt_r;
  logic [15:0]         win_cnt_r;
  logic                conv_end;
  logic                win_end;
  logic                in_win;
  adb_cfg_t            cfg_r;
  adb_cfg_t            cfg_conv_r;
  logic [12:0]         cfg_sh_r;
  logic [3:0]          rise_cnt_r;
  logic [`ADB_SH_W-1:0] out_sh_r;
  logic [4:0]          fall_cnt_r;
  logic [4:0]          last_fall;
  logic                res_ok_r;
  logic                rb_on_r;
  logic                done_r;
  logic                sdo_r;
  logic                oe_r;
  logic                busy_r;
  logic                done_pls_r;
  logic                applied_r;
  logic                lost_r;

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs: two stages, third only for edge finding
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pin_a_r <= `ADB_PIN_IDLE;
      pin_b_r <= `ADB_PIN_IDLE;
      pin_c_r <= `ADB_PIN_IDLE;
    end else if (CE) begin
      pin_a_r <= {LINK.conversion_start, LINK.sck, LINK.din};
      pin_b_r <= pin_a_r;
      pin_c_r <= pin_b_r;
    end
  end

  // Edges of the synchronised pins
  assign cnv_s    = pin_b_r[`ADB_PIN_CNV];
  assign din_s    = pin_b_r[`ADB_PIN_DIN];
  assign cnv_rise = pin_b_r[`ADB_PIN_CNV] & ~pin_c_r[`ADB_PIN_CNV];
  assign sck_rise = pin_b_r[`ADB_PIN_SCK] & ~pin_c_r[`ADB_PIN_SCK];
  assign sck_fall = ~pin_b_r[`ADB_PIN_SCK] & pin_c_r[`ADB_PIN_SCK];

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer; start edges during a conversion are ignored
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r    <= ADB_DEV_ACQ;
      conv_cnt_r <= '0;
    end else if (CE) begin
      case (state_r)
        ADB_DEV_ACQ: begin
          if (cnv_rise) begin
            state_r    <= ADB_DEV_CONV;
            conv_cnt_r <= 16'(CONV_CYC - 1);
          end
        end
        ADB_DEV_CONV: begin
          if (conv_cnt_r == '0) begin
            state_r <= ADB_DEV_ACQ;
          end else begin
            conv_cnt_r <= conv_cnt_r - 16'h0001;
          end
        end
        default: begin
          state_r <= ADB_DEV_ACQ;
        end
      endcase
    end
  end

  assign conv_end = (state_r == ADB_DEV_CONV) && (conv_cnt_r == '0);

  // Safe transfer window, counted from each conversion start
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      win_cnt_r <= '0;
    end else if (CE) begin
      if ((state_r == ADB_DEV_ACQ) && cnv_rise) begin
        win_cnt_r <= 16'(TDATA_CYC);
      end else if (win_cnt_r != '0) begin
        win_cnt_r <= win_cnt_r - 16'h0001;
      end
    end
  end

  // Old data stays reachable in acquisition and early in the next conversion
  assign win_end = (win_cnt_r == 16'h0001);
  assign in_win  = (state_r == ADB_DEV_ACQ) || (win_cnt_r != '0);

  ////////////////////////////////////////////////////////////////////////
  // Configuration input: shift first 14 rising edges, apply only if complete
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cfg_r      <= `ADB_CFG_RST;
      cfg_sh_r   <= '0;
      rise_cnt_r <= '0;
      applied_r  <= 1'b0;
    end else if (CE) begin
      applied_r <= 1'b0;
      if (conv_end || win_end) begin
        rise_cnt_r <= '0;
      end else if (sck_rise && !cnv_s && in_win && (rise_cnt_r < `ADB_CFG_BITS)) begin
        cfg_sh_r   <= {cfg_sh_r[11:0], din_s};
        rise_cnt_r <= rise_cnt_r + 4'h1;
        if (rise_cnt_r == `ADB_CFG_BITS - 4'h1) begin
          cfg_r     <= {cfg_sh_r, din_s};
          applied_r <= 1'b1;
        end
      end
    end
  end

  // Word in force for each conversion, kept for its readback
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cfg_conv_r <= `ADB_CFG_RST;
    end else if (CE) begin
      if ((state_r == ADB_DEV_ACQ) && cnv_rise) begin
        cfg_conv_r <= cfg_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result output shifter; falling edge launches, so bit spans both next edges
  assign last_fall = rb_on_r ? `ADB_ALL_BITS : `ADB_RES_BITS;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      out_sh_r   <= '0;
      fall_cnt_r <= '0;
      res_ok_r   <= 1'b0;
      rb_on_r    <= 1'b0;
      done_r     <= 1'b0;
      sdo_r      <= 1'b0;
    end else if (CE) begin
      if (conv_end) begin
        out_sh_r   <= {SAMPLE, cfg_conv_r};
        rb_on_r    <= ~cfg_conv_r[`ADB_CFG_RBDIS];
        fall_cnt_r <= '0;
        res_ok_r   <= 1'b1;
        done_r     <= 1'b0;
        sdo_r      <= 1'b0;
      end else if (win_end) begin
        res_ok_r <= 1'b0;
      end else if (sck_fall && !cnv_s && res_ok_r && in_win && !done_r) begin
        if (fall_cnt_r == last_fall) begin
          done_r <= 1'b1;
        end else begin
          sdo_r      <= out_sh_r[`ADB_SH_W-1];
          out_sh_r   <= {out_sh_r[`ADB_SH_W-2:0], 1'b0};
          fall_cnt_r <= fall_cnt_r + 5'h01;
        end
      end
    end
  end

  // Drive only while start is low; last bit held until the window after the next start ends
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      oe_r <= 1'b0;
    end else if (CE) begin
      oe_r <= !cnv_s && res_ok_r && in_win && !done_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // User-side status
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      busy_r     <= 1'b0;
      done_pls_r <= 1'b0;
      lost_r     <= 1'b0;
    end else if (CE) begin
      busy_r     <= (state_r == ADB_DEV_CONV);
      done_pls_r <= conv_end;
      lost_r     <= win_end && res_ok_r && (fall_cnt_r < `ADB_RES_BITS);
    end
  end

  assign LINK.sdo_o   = sdo_r;
  assign LINK.sdo_oe  = oe_r;
  assign CFG_OUT      = cfg_r;
  assign CONV_BUSY    = busy_r;
  assign CONV_DONE    = done_pls_r;
  assign CFG_APPLIED  = applied_r;
  assign RESULT_LOST  = lost_r;
endmodule : adb_dev

// ---- adb_host.sv ----
// Host end: AXI4-Lite registers driving conversions and serial transfers
`timescale 1ns/100ps
`include "adb_defines.svh"

module adb_host (
  input  wire logic                   CLK,
  input  wire logic                   SYS_RST,
  input  wire logic                   CE,
  adb_link_if.host                    LINK,
  input  wire logic [`ADB_AXI_AW-1:0] AWADDR,
  input  wire logic                   AWVALID,
  output      logic                   AWREADY,
  input  wire logic [31:0]            WDATA,
  input  wire logic [3:0]             WSTRB,
  input  wire logic                   WVALID,
  output      logic                   WREADY,
  output      logic [1:0]             BRESP,
  output      logic                   BVALID,
  input  wire logic                   BREADY,
  input  wire logic [`ADB_AXI_AW-1:0] ARADDR,
  input  wire logic                   ARVALID,
  output      logic                   ARREADY,
  output      logic [31:0]            RDATA,
  output      logic [1:0]             RRESP,
  output      logic                   RVALID,
  input  wire logic                   RREADY
);
  import adb_pkg::*;

  localparam adb_cfg_t CFG_RST = `ADB_CFG_RST;

  logic [`ADB_AXI_AW-1:0] awaddr_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic                   aw_got_r;
  logic                   w_got_r;
  logic                   start_r;
  logic                   done_r;
  adb_cfg_t               cfg_r;
  adb_res_t               res_r;
  adb_cfg_t               rbcfg_r;
  adb_host_e              hs_r;
  logic [7:0]             tmr_r;
  logic [4:0]             nfall_r;
  logic [`ADB_SH_W-1:0]   in_sh_r;
  logic [12:0]            din_sh_r;
  logic                   pend_rbdis_r;
  logic                   conv_rbdis_r;
  logic                   sdo_a_r;
  logic                   sdo_b_r;
  logic                   cnv_r;
  logic                   sck_r;
  logic                   din_r;
  logic                   wr_go;
  logic                   fin;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data in either order, response after both
  assign wr_go = aw_got_r && w_got_r && !BVALID;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      AWREADY  <= 1'b1;
      WREADY   <= 1'b1;
      BVALID   <= 1'b0;
      BRESP    <= `ADB_RESP_OK;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (CE) begin
      if (AWVALID && AWREADY) begin
        awaddr_r <= AWADDR;
        aw_got_r <= 1'b1;
        AWREADY  <= 1'b0;
      end
      if (WVALID && WREADY) begin
        wdata_r <= WDATA;
        wstrb_r <= WSTRB;
        w_got_r <= 1'b1;
        WREADY  <= 1'b0;
      end
      if (wr_go) begin
        BVALID <= 1'b1;
        if ((awaddr_r == `ADB_REG_CTRL) || (awaddr_r == `ADB_REG_CFG)) begin
          BRESP <= `ADB_RESP_OK;
        end else begin
          BRESP <= `ADB_RESP_ERR;
        end
      end else if (BVALID && BREADY) begin
        BVALID   <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        AWREADY  <= 1'b1;
        WREADY   <= 1'b1;
      end
    end
  end

  // Writable registers; a start asked for while busy waits its turn
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      start_r <= 1'b0;
      cfg_r   <= `ADB_CFG_RST;
    end else if (CE) begin
      if (hs_r == HS_IDLE) begin
        start_r <= 1'b0;
      end
      if (wr_go && (awaddr_r == `ADB_REG_CTRL) && wstrb_r[0] && wdata_r[`ADB_CTRL_START]) begin
        start_r <= 1'b1;
      end
      if (wr_go && (awaddr_r == `ADB_REG_CFG)) begin
        if (wstrb_r[0]) begin
          cfg_r[7:0] <= wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
          cfg_r[13:8] <= wdata_r[13:8];
        end
      end
    end
  end

  // AXI4-Lite read
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= '0;
      RRESP   <= `ADB_RESP_OK;
    end else if (CE) begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RRESP   <= `ADB_RESP_OK;
        if (ARADDR == `ADB_REG_CTRL) begin
          RDATA <= {31'h0000_0000, start_r};
        end else if (ARADDR == `ADB_REG_CFG) begin
          RDATA <= {18'h0_0000, cfg_r};
        end else if (ARADDR == `ADB_REG_STAT) begin
          RDATA <= {30'h0000_0000, done_r, (hs_r != HS_IDLE) || start_r};
        end else if (ARADDR == `ADB_REG_RES) begin
          RDATA <= {16'h0000, res_r};
        end else if (ARADDR == `ADB_REG_RBCFG) begin
          RDATA <= {18'h0_0000, rbcfg_r};
        end else begin
          RDATA <= '0;
          RRESP <= `ADB_RESP_ERR;
        end
      end else if (RVALID && RREADY) begin
        RVALID  <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data line comes from the device's side: two flops first
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sdo_a_r <= 1'b1;
      sdo_b_r <= 1'b1;
    end else if (CE) begin
      sdo_a_r <= LINK.sdo;
      sdo_b_r <= sdo_a_r;
    end
  end

  // Transfer ends with the edge that floats the data line
  assign fin = (nfall_r == (conv_rbdis_r ? `ADB_RES_BITS + 5'h01 : `ADB_ALL_BITS + 5'h01));

  // Link sequencer: clock idles high, config bit set at fall, data sampled at rise
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      hs_r         <= HS_IDLE;
      cnv_r        <= 1'b0;
      sck_r        <= 1'b1;
      din_r        <= 1'b0;
      tmr_r        <= '0;
      nfall_r      <= '0;
      in_sh_r      <= '0;
      din_sh_r     <= '0;
      res_r        <= '0;
      rbcfg_r      <= '0;
      done_r       <= 1'b0;
      pend_rbdis_r <= CFG_RST[`ADB_CFG_RBDIS];
      conv_rbdis_r <= CFG_RST[`ADB_CFG_RBDIS];
    end else if (CE) begin
      if (tmr_r != '0) begin
        tmr_r <= tmr_r - 8'h01;
      end
      case (hs_r)
        HS_IDLE: begin
          if (start_r) begin
            cnv_r        <= 1'b1;
            done_r       <= 1'b0;
            conv_rbdis_r <= pend_rbdis_r;
            tmr_r        <= 8'(`ADB_CNV_HI_CYC - 1);
            hs_r         <= HS_CNV;
          end
        end
        HS_CNV: begin
          if (tmr_r == '0) begin
            cnv_r <= 1'b0;
            hs_r  <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (!sdo_b_r) begin
            din_r    <= cfg_r[13];
            din_sh_r <= cfg_r[12:0];
            sck_r    <= 1'b0;
            nfall_r  <= 5'h01;
            tmr_r    <= 8'(`ADB_SCK_HALF_CYC - 1);
            hs_r     <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tmr_r == '0) begin
            sck_r    <= 1'b1;
            // Only data bits are kept; the edge that floats the line adds none
            if (nfall_r <= (conv_rbdis_r ? `ADB_RES_BITS : `ADB_ALL_BITS)) begin
              in_sh_r <= {in_sh_r[`ADB_SH_W-2:0], sdo_b_r};
            end
            tmr_r <= 8'(`ADB_SCK_HALF_CYC - 1);
            hs_r  <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (tmr_r == '0) begin
            if (fin) begin
              done_r       <= 1'b1;
              pend_rbdis_r <= cfg_r[`ADB_CFG_RBDIS];
              hs_r         <= HS_IDLE;
              if (conv_rbdis_r) begin
                res_r <= in_sh_r[15:0];
              end else begin
                res_r   <= in_sh_r[`ADB_SH_W-1:14];
                rbcfg_r <= in_sh_r[13:0];
              end
            end else begin
              // Config bit moves on the fall, so it stands at the next rise
              sck_r    <= 1'b0;
              din_r    <= din_sh_r[12];
              din_sh_r <= {din_sh_r[11:0], 1'b0};
              nfall_r  <= nfall_r + 5'h01;
              tmr_r   <= 8'(`ADB_SCK_HALF_CYC - 1);
              hs_r    <= HS_LOW;
            end
          end
        end
        default: begin
          hs_r <= HS_IDLE;
        end
      endcase
    end
  end

  assign LINK.conversion_start = cnv_r;
  assign LINK.sck = sck_r;
  assign LINK.din = din_r;
endmodule : adb_host

// ---- adb_link_properties.sv ----
// Concurrent checks on the serial link between host and converter ends
`timescale 1ns/100ps
module adb_link_properties #(
  parameter int CONV_CYC = 320
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic conversion_start,
  input wire logic sck,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  // Sync and register stages add a few cycles on top of the conversion
  localparam int C_LO = CONV_CYC;
  localparam int C_HI = CONV_CYC + 10;
  logic [5:0] nfall_r;
  logic       sck_r;

  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  ////////////////////////////////////////////////////////////////////////////
  // Falling clock edges per frame; a start clears the tally
  always_ff @(posedge CLK) begin
    sck_r <= SYS_RST ? 1'b1 : sck;
    if (SYS_RST || conversion_start) nfall_r <= 6'h0;
    else if (sck_r && !sck) nfall_r <= nfall_r + 6'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_sck_idle;
    conversion_start |-> sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock not high at start");
  property p_cnv_float;
    $rose(conversion_start) |-> ##[1:6] !sdo_oe;
  endproperty
  a_cnv_float: assert property (p_cnv_float) else $error("output not floated");
  property p_conv_done;
    $rose(conversion_start) |-> ##[C_LO:C_HI] $rose(sdo_oe);
  endproperty
  a_conv_done: assert property (p_conv_done) else $error("no end of conversion");
  property p_cnv_pulse;
    $rose(conversion_start) |-> conversion_start [*8] ##1 !conversion_start;
  endproperty
  a_cnv_pulse: assert property (p_cnv_pulse) else $error("start pulse length");
  property p_busy_low;
    $rose(sdo_oe) |-> !sdo_o;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy level not low");
  property p_bit_stable;
    sdo_oe && $past(sdo_oe) && $changed(sck) |-> $stable(sdo_o);
  endproperty
  a_bit_stable: assert property (p_bit_stable) else $error("bit moved at edge");
  property p_release;
    $fell(sdo_oe) && !conversion_start |-> (nfall_r == 6'h11) || (nfall_r == 6'h1F);
  endproperty
  a_release: assert property (p_release) else $error("release count");
  property p_fall_max;
    nfall_r <= 6'h1F;
  endproperty
  a_fall_max: assert property (p_fall_max) else $error("too many falls");
endmodule : adb_link_properties

// ---- testbench.sv ----
// Self-checking bench: host and converter joined, plus a faulty frame driver
`timescale 1ns/100ps
`include "adb_defines.svh"
module testbench;
  import adb_pkg::*;
  // Shortened conversion and window keep the run small
  localparam int CONV = 40;
  localparam int TDAT = 30;
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, app1, lost1, app2, lost2;
  logic        busy1, done1;
  logic [31:0] wdata = '0, rdata;
  logic [1:0]  bresp, rresp;
  adb_res_t    smp1 = '0, smp2 = 16'hC6A9;
  adb_cfg_t    cfg1, cfg2;
  int          fails = 0, n_compared = 0, n_app1 = 0, n_lost1 = 0, n_app2 = 0, n_lost2 = 0;
  int          n_busy1 = 0, n_done1 = 0;
  adb_link_if l1 ();
  adb_link_if l2 ();

  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  adb_host adb_host_i (.CLK(clk), .SYS_RST(sys_rst), .CE(1'b1), .LINK(l1.host),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready));
  adb_dev #(.CONV_CYC(CONV), .TDATA_CYC(TDAT)) adb_dev_i (.CLK(clk), .SYS_RST(sys_rst),
    .CE(1'b1), .LINK(l1.dev), .SAMPLE(smp1), .CFG_OUT(cfg1), .CONV_BUSY(busy1),
    .CONV_DONE(done1), .CFG_APPLIED(app1), .RESULT_LOST(lost1));
  // Second device faces the bench, which breaks the host's side on purpose
  adb_dev #(.CONV_CYC(CONV), .TDATA_CYC(TDAT)) adb_dev_fault_i (.CLK(clk),
    .SYS_RST(sys_rst), .CE(1'b1), .LINK(l2.dev), .SAMPLE(smp2), .CFG_OUT(cfg2),
    .CONV_BUSY(), .CONV_DONE(), .CFG_APPLIED(app2), .RESULT_LOST(lost2));
  adb_link_properties #(.CONV_CYC(CONV)) adb_link_properties_i (.CLK(clk),
    .SYS_RST(sys_rst), .conversion_start(l1.conversion_start), .sck(l1.sck), .sdo_o(l1.sdo_o), .sdo_oe(l1.sdo_oe));

  // Pulse tallies of both devices
  always @(posedge clk) begin
    if (app1 === 1'b1) n_app1++;
    if (busy1 === 1'b1) n_busy1++;
    if (done1 === 1'b1) n_done1++;
    if (lost1 === 1'b1) n_lost1++;
    if (app2 === 1'b1) n_app2++;
    if (lost2 === 1'b1) n_lost2++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Both channels offered together; bready held until the answer
  // No cycle count assumed: only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(`ADB_REG_CFG, d, r);
    chk(d, 32'h0000_0001);
    rd(`ADB_REG_STAT, d, r);
    chk(d, 32'h0);
    wr(`ADB_REG_STAT, 32'h3, r);
    chk(32'(r), 32'h2);
    wr(8'h20, 32'h1, r);
    chk(32'(r), 32'h2);
    rd(8'h20, d, r);
    chk(32'(r), 32'h2);
    chk(d, 32'h0);
  endtask : t_regs

  // One full frame: write config, start, wait for done, read the result
  task automatic conv(input adb_cfg_t c, input adb_res_t s);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    smp1 <= s;
    wr(`ADB_REG_CFG, 32'(c), r);
    wr(`ADB_REG_CTRL, 32'h1, r);
    d = '0;
    for (n = 0; n < 2000 && d[1:0] !== 2'b10; n++) rd(`ADB_REG_STAT, d, r);
    chk(32'(d[1:0]), 32'h2);
    rd(`ADB_REG_RES, d, r);
    chk(d, 32'(s));
  endtask : conv

  task automatic t_frames;
    logic [31:0] d;
    logic [1:0]  r;
    conv(14'h2A56, 16'hA5C3);
    conv(14'h1F3B, 16'h5A3C);
    rd(`ADB_REG_RBCFG, d, r);
    chk(d, 32'h0000_2A56);
    conv(14'h0000, 16'h8001);
    rd(`ADB_REG_RBCFG, d, r);
    chk(d, 32'h0000_2A56);
    chk(32'(n_app1), 32'h3);
    chk(32'(n_lost1), 32'h0);
    chk(32'(n_done1), 32'h3);
    chk(32'(n_busy1), 32'(3 * CONV));
    chk(32'(cfg1), 32'h0);
  endtask : t_frames

  // Five bits only, then a new start: config must be dropped, result lost
  task automatic t_partial;
    logic [4:0] got;
    int         n;
    l2.conversion_start <= 1'b1;
    repeat (8) @(posedge clk);
    l2.conversion_start <= 1'b0;
    for (n = 0; n < 200 && l2.sdo !== 1'b0; n++) @(posedge clk);
    chk(32'(l2.sdo), 32'h0);
    for (n = 4; n >= 0; n--) begin
      l2.sck <= 1'b0;
      l2.din <= 1'b1;
      repeat (16) @(posedge clk);
      l2.sck <= 1'b1;
      got[n] = l2.sdo;
      repeat (16) @(posedge clk);
    end
    chk(32'(got), 32'(smp2[15:11]));
    l2.conversion_start <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(l2.sdo), 32'h1);
    repeat (2) @(posedge clk);
    l2.conversion_start <= 1'b0;
    repeat (CONV + TDAT + 20) @(posedge clk);
    chk(32'(l2.sdo), 32'h0);
    chk(32'(n_app2), 32'h0);
    chk(32'(n_lost2), 32'h1);
    chk(32'(cfg2), 32'h1);
  endtask : t_partial

  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    l2.conversion_start = 1'b0;
    l2.sck = 1'b1;
    l2.din = 1'b0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_frames();
    t_partial();
    summarize();
  end

  // Watchdog: tests need a few thousand cycles, this allows twenty thousand
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule : testbench
